// ### hw/sbsic_pkg.sv
// shared constants for the burst sram input control block
package sbsic_pkg;
  localparam int ADDR_W    = 8;  // default address width
  localparam int LANES     = 4;  // byte lanes
  localparam int BYTE_W    = 8;  // data bits per lane
  localparam int LANE_W    = 9;  // byte plus parity bit
  localparam int BURST_W   = 2;  // burst counter width
  localparam logic [1:0] BURST_ONE = 2'h1;
  localparam logic       SEL_A_ON  = 1'h0;  // first select active level
  localparam logic       SEL_B_ON  = 1'h1;  // second select active level
  localparam logic       SEL_C_ON  = 1'h0;  // third select active level
  localparam logic       QUAL_ON   = 1'h0;  // clock qualifier active level
  localparam logic       WE_ON     = 1'h0;  // write enable active level
  localparam logic       ADV_ON    = 1'h1;  // advance/load high advances
  localparam logic       MODE_INTL = 1'h1;  // burst order strap high: interleaved

  // states of the access sequencer
  typedef enum logic [1:0] {
    SBSIC_IDLE  = 2'b00,
    SBSIC_READ  = 2'b01,
    SBSIC_WRITE = 2'b10
  } sbsic_state_t;
endpackage

// ### hw/sbsic_mem.sv
// small byte-lane memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module sbsic_mem #(
  parameter int AW = sbsic_pkg::ADDR_W
) (
  input  wire logic                                          clk_in,
  input  wire logic                                          ce_in,
  input  wire logic [AW-1:0]                                 addr_in,
  input  wire logic [sbsic_pkg::LANES-1:0]                   lane_we_in,
  input  wire logic [sbsic_pkg::LANES*sbsic_pkg::LANE_W-1:0] wdata_in,
  output logic      [sbsic_pkg::LANES*sbsic_pkg::LANE_W-1:0] rdata_out
);
  logic [sbsic_pkg::LANES*sbsic_pkg::LANE_W-1:0] store [0:(1<<AW)-1];

  // per-lane write, registered read
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      for (int i = 0; i < sbsic_pkg::LANES; i++) begin
        if (lane_we_in[i]) begin
          store[addr_in][i*sbsic_pkg::LANE_W +: sbsic_pkg::LANE_W] <=
            wdata_in[i*sbsic_pkg::LANE_W +: sbsic_pkg::LANE_W];
        end
      end
      rdata_out <= store[addr_in];
    end
  end
endmodule
`default_nettype wire

// ### hw/sbsic_burst.sv
// burst address sequencer, linear or interleaved
`timescale 1ns/1ns
`default_nettype none
module sbsic_burst (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          ce_in,
  input  wire logic                          load_in,
  input  wire logic                          adv_in,
  input  wire logic                          interleave_in,
  input  wire logic [sbsic_pkg::BURST_W-1:0] start_in,
  output logic      [sbsic_pkg::BURST_W-1:0] low_out
);
  logic [sbsic_pkg::BURST_W-1:0] start;
  logic [sbsic_pkg::BURST_W-1:0] count;
  logic [sbsic_pkg::BURST_W-1:0] next_start;
  logic [sbsic_pkg::BURST_W-1:0] next_count;
  logic [sbsic_pkg::BURST_W-1:0] next_low;

  // pick next count and the low address bits it implies
  always_comb begin
    next_start = start;
    next_count = count;
    if (load_in) begin
      next_start = start_in;
      next_count = '0;
    end else if (adv_in) begin
      next_count = count + sbsic_pkg::BURST_ONE;
    end
    if (interleave_in) begin
      next_low = next_start ^ next_count;
    end else begin
      next_low = next_start + next_count;
    end
  end

  // register sequencer state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      start   <= '0;
      count   <= '0;
      low_out <= '0;
    end else if (ce_in) begin
      start   <= next_start;
      count   <= next_count;
      low_out <= next_low;
    end
  end
endmodule
`default_nettype wire

// ### hw/sbsic_top.sv
// input capture and command decode of a pipelined burst sram
`timescale 1ns/1ns
`default_nettype none
module sbsic_top #(
  parameter int AW = sbsic_pkg::ADDR_W
) (
  input  wire logic                                          clk_in,
  input  wire logic                                          rst_in,
  input  wire logic                                          clock_qualifier_n_in,
  input  wire logic [AW-1:0]                                 addr_in,
  input  wire logic                                          lane0_write_strobe_n_in,
  input  wire logic                                          lane1_write_strobe_n_in,
  input  wire logic                                          lane2_write_strobe_n_in,
  input  wire logic                                          lane3_write_strobe_n_in,
  input  wire logic                                          write_enable_n_in,
  input  wire logic                                          advance_or_load_in,
  input  wire logic                                          chip_select_a_n_in,
  input  wire logic                                          chip_select_b_in,
  input  wire logic                                          chip_select_c_n_in,
  input  wire logic                                          output_enable_n_in,
  input  wire logic                                          burst_mode_in,
  input  wire logic [sbsic_pkg::LANES*sbsic_pkg::LANE_W-1:0] data_in,
  output logic      [sbsic_pkg::LANES*sbsic_pkg::LANE_W-1:0] data_out,
  output logic      [sbsic_pkg::LANES*sbsic_pkg::LANE_W-1:0] data_oe_n_out,
  output logic                                               selected_out
);
  localparam int DW = sbsic_pkg::LANES * sbsic_pkg::LANE_W;
  localparam int BW = sbsic_pkg::BURST_W;

  // one when the clock edge is recognised
  logic ce;
  assign ce = (clock_qualifier_n_in == sbsic_pkg::QUAL_ON);

  // ------------------------------------------------------------
  // input registers
  // ------------------------------------------------------------
  logic [AW-1:0]               addr_q;
  logic [sbsic_pkg::LANES-1:0] strobe_n_q;
  logic                        we_n_q;
  logic                        adv_q;
  logic                        sel_q;
  logic                        mode_q;
  logic [AW-1:0]               next_addr_q;
  logic [sbsic_pkg::LANES-1:0] next_strobe_n_q;
  logic                        next_we_n_q;
  logic                        next_adv_q;
  logic                        next_sel_q;

  // decide selection from the three selects
  function automatic logic sbsic_sel(input logic a_n, input logic b, input logic c_n);
    sbsic_sel = (a_n == sbsic_pkg::SEL_A_ON) && (b == sbsic_pkg::SEL_B_ON) &&
                (c_n == sbsic_pkg::SEL_C_ON);
  endfunction

  // next values of the input register set
  always_comb begin
    next_addr_q     = addr_in;
    next_strobe_n_q = {lane3_write_strobe_n_in, lane2_write_strobe_n_in,
                       lane1_write_strobe_n_in, lane0_write_strobe_n_in};
    next_we_n_q     = write_enable_n_in;
    next_adv_q      = advance_or_load_in;
    next_sel_q      = sbsic_sel(chip_select_a_n_in, chip_select_b_in,
                                chip_select_c_n_in);
  end

  // capture address, strobes, write enable, advance and selects on qualified rising edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_q     <= '0;
      strobe_n_q <= '1;
      we_n_q     <= 1'h1;
      adv_q      <= 1'h0;
      sel_q      <= 1'h0;
    end else if (ce) begin
      addr_q     <= next_addr_q;
      strobe_n_q <= next_strobe_n_q;
      we_n_q     <= next_we_n_q;
      adv_q      <= next_adv_q;
      sel_q      <= next_sel_q;
    end
  end

  // strap caught at the first edge after reset release, static afterwards
  logic mode_taken;
  logic next_mode_q;
  logic next_mode_taken;
  always_comb begin
    next_mode_q     = mode_q;
    next_mode_taken = 1'h1;
    if (!mode_taken) begin
      next_mode_q = burst_mode_in;
    end
  end

  // register the strap; a later change of the pin is ignored
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q     <= sbsic_pkg::MODE_INTL;
      mode_taken <= 1'h0;
    end else begin
      mode_q     <= next_mode_q;
      mode_taken <= next_mode_taken;
    end
  end

  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  sbsic_pkg::sbsic_state_t state;
  sbsic_pkg::sbsic_state_t next_state;
  logic [AW-1:BW]          base;
  logic [AW-1:BW]          next_base;
  logic                    emerge;
  logic                    next_emerge;
  logic                    load;
  logic                    advance;

  // load on advance low while selected, advance on high while busy
  assign load    = sel_q && (adv_q != sbsic_pkg::ADV_ON);
  assign advance = (adv_q == sbsic_pkg::ADV_ON) &&
                   (state != sbsic_pkg::SBSIC_IDLE);

  // next access state
  always_comb begin
    next_state  = state;
    next_base   = base;
    next_emerge = 1'h0;
    case (state)
      sbsic_pkg::SBSIC_IDLE: begin
        if (load) begin
          next_emerge = 1'h1;
        end
      end
      default: begin
      end
    endcase
    if (load) begin
      next_base = addr_q[AW-1:BW];
      if (we_n_q == sbsic_pkg::WE_ON) begin
        next_state = sbsic_pkg::SBSIC_WRITE;
      end else begin
        next_state = sbsic_pkg::SBSIC_READ;
      end
    end else if (!advance) begin
      next_state = sbsic_pkg::SBSIC_IDLE; // deselect or advance with no access
    end
  end

  // register sequencer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state  <= sbsic_pkg::SBSIC_IDLE;
      base   <= '0;
      emerge <= 1'h0;
    end else if (ce) begin
      state  <= next_state;
      base   <= next_base;
      emerge <= next_emerge;
    end
  end

  // burst low address bits
  logic [BW-1:0] low;
  sbsic_burst u_burst (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce),
    .load_in       (load),
    .adv_in        (advance),
    .interleave_in (mode_q == sbsic_pkg::MODE_INTL),
    .start_in      (addr_q[BW-1:0]),
    .low_out       (low)
  );

  // ------------------------------------------------------------
  // memory access
  // ------------------------------------------------------------
  logic [AW-1:0]               mem_addr;
  logic [sbsic_pkg::LANES-1:0] lane_we;
  logic [sbsic_pkg::LANES-1:0] wr_strobe_n;
  logic [DW-1:0]               rdata;
  logic                        is_write;

  // strobes held with the write command for its data phase
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_strobe_n <= '1;
    end else if (ce && load) begin
      wr_strobe_n <= strobe_n_q;
    end
  end

  assign is_write = (state == sbsic_pkg::SBSIC_WRITE);
  assign mem_addr = {base, low};
  assign lane_we  = is_write ? ~wr_strobe_n : '0;

  sbsic_mem #(
    .AW (AW)
  ) u_mem (
    .clk_in     (clk_in),
    .ce_in      (ce),
    .addr_in    (mem_addr),
    .lane_we_in (lane_we),
    .wdata_in   (data_in),
    .rdata_out  (rdata)
  );

  // ------------------------------------------------------------
  // output pipeline and drive control
  // ------------------------------------------------------------
  logic          drive;
  logic          next_drive;
  logic [DW-1:0] next_data;
  logic          rd_phase;
  logic          next_rd_phase;

  // drive only a read that is not the emerge cycle; the memory registers
  // its word, so read data trail the read state by one edge
  always_comb begin
    next_drive    = (state == sbsic_pkg::SBSIC_READ) && !emerge;
    next_rd_phase = (state == sbsic_pkg::SBSIC_READ);
    next_data     = data_out;
    if (rd_phase) begin
      next_data = rdata;
    end
  end

  // register outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive        <= 1'h0;
      rd_phase     <= 1'h0;
      data_out     <= '0;
      data_oe_n_out <= '1;
      selected_out <= 1'h0;
    end else begin
      if (ce) begin
        drive        <= next_drive;
        rd_phase     <= next_rd_phase;
        data_out     <= next_data;
        selected_out <= sel_q;
      end
      data_oe_n_out <= {DW{!(drive && (output_enable_n_in == 1'h0))}};
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_hold_on_qual: assert property (@(posedge clk_in) disable iff (rst_in)
    !ce |=> $stable(state) && $stable(addr_q) && $stable(sel_q))
    else $error("state moved while clock qualifier high");
  a_write_needs_we: assert property (@(posedge clk_in) disable iff (rst_in)
    ce && !(load && (we_n_q == sbsic_pkg::WE_ON)) && !advance |=> (lane_we == '0))
    else $error("lane write without write enable");
  a_lane_match: assert property (@(posedge clk_in) disable iff (rst_in)
    ce && load && (we_n_q == sbsic_pkg::WE_ON) |=> (lane_we == ~$past(strobe_n_q)))
    else $error("lane enable mismatch");
  a_sel_decode: assert property (@(posedge clk_in) disable iff (rst_in)
    ce |=> sel_q == ($past(chip_select_a_n_in) == 1'h0 && $past(chip_select_b_in) &&
                     $past(chip_select_c_n_in) == 1'h0))
    else $error("select decode wrong");
  a_we_start: assert property (@(posedge clk_in) disable iff (rst_in)
    ce && load && we_n_q == 1'h0 |=> state == sbsic_pkg::SBSIC_WRITE)
    else $error("write not started");
  a_read_start: assert property (@(posedge clk_in) disable iff (rst_in)
    ce && load && we_n_q == 1'h1 |=> state == sbsic_pkg::SBSIC_READ &&
                                     base == $past(addr_q[AW-1:BW]))
    else $error("read not loaded");
  a_addr_capture: assert property (@(posedge clk_in) disable iff (rst_in)
    ce |=> addr_q == $past(addr_in))
    else $error("address not captured");
  a_no_drive_write: assert property (@(posedge clk_in) disable iff (rst_in)
    ce && (is_write || emerge || state == sbsic_pkg::SBSIC_IDLE) |=> ##1 data_oe_n_out == '1)
    else $error("data driven during write or deselect");
  a_oe_masked: assert property (@(posedge clk_in) disable iff (rst_in)
    (output_enable_n_in != 1'h0) |=> (data_oe_n_out == '1))
    else $error("data driven with output enable high");
  a_sel_out: assert property (@(posedge clk_in) disable iff (rst_in)
    ce |=> (selected_out == $past(sel_q)))
    else $error("selection flag not registered");
  a_strap_static: assert property (@(posedge clk_in) disable iff (rst_in)
    mode_taken |=> $stable(mode_q))
    else $error("burst order changed in operation");
  a_read_data: assert property (@(posedge clk_in) disable iff (rst_in)
    ce && rd_phase |=> (data_out == $past(rdata)))
    else $error("read word not passed out");
endmodule
`default_nettype wire

// ### verification/sbsic_ctrl_model.sv
// controller-side driver model for the burst sram input block
`timescale 1ns/1ns
`default_nettype none
module sbsic_ctrl_model (
  input  wire logic        clk_in,
  output logic             qual_n_out,
  output logic [7:0]       addr_out,
  output logic [3:0]       strobe_n_out,
  output logic             we_n_out,
  output logic             adv_out,
  output logic [2:0]       cs_out,
  output logic [35:0]      data_out
);
  // idle: qualified, deselected, load
  initial begin
    qual_n_out   = 1'h0;
    addr_out     = 8'h00;
    strobe_n_out = 4'hf;
    we_n_out     = 1'h1;
    adv_out      = 1'h0;
    cs_out       = 3'h7;
    data_out     = 36'h0;
  end
  // one bus cycle, changed 10 ns after the edge
  task automatic step(input logic q, input logic [2:0] c, input logic w,
                      input logic v, input logic [7:0] a, input logic [3:0] s,
                      input logic [35:0] d);
    qual_n_out   = q;
    cs_out       = c;
    we_n_out     = w;
    adv_out      = v;
    addr_out     = a;
    strobe_n_out = s;
    data_out     = w ? ~data_out : d;  // released bus toggles, no stale value
    @(posedge clk_in);
    #10;
  endtask
endmodule
`default_nettype wire

// ### verification/sync_burst_sram_input_ctrl_bench.sv
// self-checking bench for the burst sram input control block
`timescale 1ns/1ns
`default_nettype none
module sync_burst_sram_input_ctrl_bench;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] DES = 3'h7;
  logic        clk_in;
  logic        rst_in;
  logic        mode;
  logic        oe_n;
  logic        qn;
  logic [7:0]  addr;
  logic [3:0]  st_n;
  logic        we_n;
  logic        adv;
  logic [2:0]  cs;
  logic [35:0] din;
  logic [35:0] dout;
  logic [35:0] doe_n;
  logic        sel;
  int          num_errors;
  int          compares;
  logic [31:0] lfsr;
  logic [35:0] mem [256];
  logic [7:0]  alist [8];
  logic [35:0] seen [$];
  logic [35:0] expq [$];

  sbsic_ctrl_model i_ctrl (.clk_in(clk_in), .qual_n_out(qn), .addr_out(addr),
    .strobe_n_out(st_n), .we_n_out(we_n), .adv_out(adv), .cs_out(cs), .data_out(din));
  sbsic_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .clock_qualifier_n_in(qn),
    .addr_in(addr), .lane0_write_strobe_n_in(st_n[0]), .lane1_write_strobe_n_in(st_n[1]),
    .lane2_write_strobe_n_in(st_n[2]), .lane3_write_strobe_n_in(st_n[3]),
    .write_enable_n_in(we_n), .advance_or_load_in(adv), .chip_select_a_n_in(cs[2]),
    .chip_select_b_in(cs[1]), .chip_select_c_n_in(cs[0]), .output_enable_n_in(oe_n),
    .burst_mode_in(mode), .data_in(din), .data_out(dout), .data_oe_n_out(doe_n),
    .selected_out(sel));

  // 100 ns clock
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // expected word after a lane-masked write
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (!s[i]) o[9*i +: 9] = n[9*i +: 9];
    return o;
  endfunction

  task automatic chk36(input logic [35:0] got, input logic [35:0] want);
    compares++;
    if (got !== want) begin
      num_errors++;
      $display("Error at %0t: word %h, expected %h", $time, got, want);
    end
  endtask
  task automatic chk1(input logic got, input logic want);
    compares++;
    if (got !== want) begin
      num_errors++;
      $display("Error at %0t: flag %b, expected %b", $time, got, want);
    end
  endtask
  task automatic test_done;
    $display("errors %0d, compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // n bus cycles, recording read data after each
  task automatic go(input logic q, input logic [2:0] c, input logic w, input logic v,
                    input logic [7:0] a, input logic [3:0] s, input logic [35:0] d,
                    input int n);
    for (int i = 0; i < n; i++) begin
      i_ctrl.step(q, c, w, v, a, s, d);
      seen.push_back(dout);
    end
  endtask
  // one write, data held while the pipe drains
  task automatic put(input logic [7:0] a, input logic [3:0] s, input logic [35:0] d,
                     input logic [2:0] c);
    go(1'h0, c, 1'h0, 1'h0, a, s, d, 1);
    go(1'h0, DES, 1'h0, 1'h0, a, 4'hf, d, 3);
    if (c == SEL) mem[a] = merge(mem[a], d, s);
  endtask
  // load, advance n-1 times, then look for the expected run of words
  task automatic rd(input logic [7:0] a, input int n);
    logic hit;
    logic ok;
    hit = 1'h0;
    seen.delete();
    go(1'h0, SEL, 1'h1, 1'h0, a, 4'hf, 36'h0, 1);
    go(1'h0, SEL, 1'h1, 1'h1, a, 4'hf, 36'h0, n - 1);
    go(1'h0, DES, 1'h1, 1'h0, a, 4'hf, 36'h0, 6);
    for (int i = 0; i + expq.size() <= seen.size(); i++) begin
      ok = 1'h1;
      foreach (expq[j]) if (seen[i + j] !== expq[j]) ok = 1'h0;
      hit = hit | ok;
    end
    chk1(hit, 1'h1);
    expq.delete();
  endtask
  // reset with a strap value, fill one burst block, read it as a burst
  task automatic burst(input logic m);
    rst_in = 1'h1;
    mode = m;
    go(1'h0, DES, 1'h1, 1'h0, 8'h00, 4'hf, 36'h0, 6);
    rst_in = 1'h0;
    for (int k = 0; k < 4; k++) put(8'(k), 4'h0, {rnd(), 4'(k)}, SEL);
    expq.push_back(mem[1]);
    expq.push_back(mem[m ? 0 : 2]);
    expq.push_back(mem[3]);
    rd(8'h01, 3);
  endtask

  // main sequence
  initial begin
    logic [31:0] r;
    logic [35:0] d0;
    logic        s0;
    lfsr = 32'h8862b3cc;
    num_errors = 0;
    compares = 0;
    rst_in = 1'h1;
    mode = 1'h1;
    oe_n = 1'h0;
    @(posedge clk_in);
    #10;
    burst(1'h1);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      alist[k] = {r[7:3], 1'h1, r[1:0]};
      put(alist[k], 4'h0, {rnd(), 4'h3}, SEL);
    end
    for (int k = 0; k < 24; k++) begin
      r = rnd();
      if (r[12]) put(alist[r[2:0]], r[11:8], {rnd(), r[7:4]}, SEL);
      else go(1'h0, SEL, 1'h1, 1'h0, alist[r[2:0]], 4'h0, 36'h0, 1);
    end
    for (int k = 0; k < 8; k++) begin
      expq.push_back(mem[alist[k]]);
      rd(alist[k], 1);
    end
    for (int c = 0; c < 8; c++) begin
      put(alist[0], 4'h0, {rnd(), 4'(c)}, 3'(c));
      go(1'h0, 3'(c), 1'h1, 1'h0, alist[0], 4'hf, 36'h0, 3);
      chk1(sel, 3'(c) == SEL);
      expq.push_back(mem[alist[0]]);
      rd(alist[0], 1);
    end
    go(1'h0, SEL, 1'h1, 1'h0, alist[1], 4'hf, 36'h0, 5);
    chk36(dout, mem[alist[1]]);
    chk36(doe_n, 36'h0);
    d0 = dout;
    s0 = sel;
    go(1'h1, SEL, 1'h0, 1'h1, alist[2], 4'h0, 36'h0, 4);
    chk36(dout, d0);
    chk1(sel, s0);
    go(1'h0, DES, 1'h1, 1'h0, alist[2], 4'hf, 36'h0, 4);
    chk36(doe_n, 36'hf_ffff_ffff);
    expq.push_back(mem[alist[2]]);
    rd(alist[2], 1);
    go(1'h0, SEL, 1'h0, 1'h0, alist[3], 4'h0, 36'h5_a5a5_a5a5, 4);
    chk36(doe_n, 36'hf_ffff_ffff);
    mem[alist[3]] = 36'h5_a5a5_a5a5;
    go(1'h0, DES, 1'h0, 1'h0, alist[3], 4'hf, 36'h5_a5a5_a5a5, 3);
    oe_n = 1'h1;
    go(1'h0, SEL, 1'h1, 1'h0, alist[3], 4'hf, 36'h0, 5);
    chk36(doe_n, 36'hf_ffff_ffff);
    chk36(dout, mem[alist[3]]);
    oe_n = 1'h0;
    burst(1'h0);
    test_done;
  end

  // watchdog: far beyond the fewer than 400 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    test_done;
  end
endmodule
`default_nettype wire
